// [logic/switch_state_map.vh]
// Constants for the switch operating-state sequencer
`ifndef SWITCH_STATE_MAP_VH
`define SWITCH_STATE_MAP_VH

// ************************************************************
// Bus register offsets (byte addresses)
// ************************************************************
`define REG_CONTROL        4'h0
`define REG_STATUS         4'h4
`define REG_CHANNEL        4'h8

// ************************************************************
// Control register fields (write)
// ************************************************************
`define CTL_SLEEP_BIT      0
`define CTL_LPM_ENTER_BIT  1
`define CTL_LPM_EXIT_BIT   2
`define CTL_WD_ENABLE_BIT  3
`define CTL_WD_KICK_BIT    4
`define CTL_POR_CLEAR_BIT  5
`define CTL_LH_CLEAR_BIT   6

// ************************************************************
// Channel register fields
// ************************************************************
`define CH_SWITCH_LSB      0
`define CH_PARALLEL_BIT    2

// ************************************************************
// Status register fields (read)
// ************************************************************
`define ST_STATE_LSB       0
`define ST_POR_BIT         4
`define ST_LH_BIT          5
`define ST_WD_EN_BIT       6
`define ST_REGS_VALID_BIT  7

// ************************************************************
// States
// ************************************************************
`define ST_OFF             3'h0
`define ST_SLEEP           3'h1
`define ST_INIT            3'h2
`define ST_ACTIVE          3'h3
`define ST_LPM             3'h4
`define ST_UVLO            3'h5
`define ST_LIMP            3'h6

// ************************************************************
// Timing
// ************************************************************
`define INIT_TIME_NS       2000
`define CLK_PERIOD_NS      10
`define INIT_CYCLES        (`INIT_TIME_NS / `CLK_PERIOD_NS)
`define WD_TIME_US         100
`define WD_CYCLES          (`WD_TIME_US * 1000 / `CLK_PERIOD_NS)

`endif

// [logic/cycle_timer.v]
// Down-counting timer with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
    parameter integer WIDTH = 16
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rst,
    // Control
    input  wire             start,
    input  wire             stop,
    input  wire [WIDTH-1:0] load,
    // Status
    output reg              running,
    output reg              done
);
    reg [WIDTH-1:0] count;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count   <= {WIDTH{1'b0}};
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (stop) begin
                running <= 1'b0;
            end else if (start) begin
                count   <= load;
                running <= 1'b1;
            end else if (running) begin
                if (count <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule

`default_nettype wire

// [logic/switch_operating_state_machine.v]
// Operating-state sequencer of a dual-channel serially controlled high-side switch
`timescale 1ns/1ps
`default_nettype none
`include "switch_state_map.vh"

// Behaviour
// RULE_01 - Power-on reset from loss of all supplies forces OFF, nothing active.
// RULE_02 - OFF goes to SLEEP when battery rises; ACTIVE goes to SLEEP on command.
// RULE_03 - SLEEP: outputs off, core unpowered, register contents lost.
// RULE_04 - Host keeps battery and logic supply powered during SLEEP.
// RULE_05 - Chip select low with logic supply good wakes SLEEP via init to CONFIG.
// RULE_06 - Host waits the ready interval after wake before real transfers.
// RULE_07 - CONFIG/ACTIVE: all registers writable, outputs on or off, diagnostics on.
// RULE_08 - Key-off with a channel still supplying uses low-power mode, not SLEEP.
// RULE_09 - Battery low with logic supply good moves ACTIVE to battery-undervoltage.
// RULE_10 - Battery good, reset released, logic good returns undervoltage to ACTIVE.
// RULE_11 - Battery-undervoltage: outputs off, registers kept, no serial or diagnostics.
// RULE_12 - Logic low, limp-home input high or watchdog failure enters limp-home.
// RULE_13 - Limp-home exits when logic good, status flag set, limp-home input low.
// RULE_14 - Limp-home outputs follow limp-home level or direct input pins.
// RULE_15 - Limp-home keeps initialised registers; serial only with logic supply present.
// RULE_16 - Low-power mode is entered and left by writes to its register.
// RULE_17 - Configuration registers are retained throughout low-power mode.
// RULE_18 - Parallel configuration bit is refused while outputs are on.
// RULE_19 - Core reset sets a readable power-on-reset status bit.
// RULE_20 - Low-power exit to ACTIVE passes self-test on command or current rise.
// RULE_21 - State resets to OFF; exactly one state active at any time.
module switch_operating_state_machine (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Avalon-MM slave
    input  wire [3:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // Supply monitors
    input  wire        batteryAbovePor,
    input  wire        batteryAboveFalling,
    input  wire        logicAboveRising,
    input  wire        logicAboveFalling,
    // Pins
    input  wire        chipSelect_n,
    input  wire        limpHomeInput,
    input  wire [1:0]  limpHomeChannelLevel,
    input  wire [1:0]  directChannelInput,
    input  wire        loadCurrentRise,
    // Outputs
    output reg  [1:0]  channelOutput,
    output reg  [2:0]  state,
    output reg         coreOn,
    output reg         diagEnable,
    output reg         lowPowerOn
);
    // ************************************************************
    // State and registers
    // ************************************************************
    localparam integer INIT_COUNT = `INIT_CYCLES;
    localparam integer WD_COUNT   = `WD_CYCLES;
    localparam [15:0]  INIT_LOAD  = INIT_COUNT[15:0];
    localparam [15:0]  WD_LOAD    = WD_COUNT[15:0];

    reg [2:0]  next_state;
    reg [1:0]  switchState;
    reg        parallel;
    reg        wdEnable;
    reg        porFlag;
    reg        limpHomeStatusFlag;
    reg        regsValid;
    reg        cmdSleep;
    reg        cmdLpmEnter;
    reg        cmdLpmExit;
    reg        wdKick;
    reg        readPending;
    reg        serialOk;
    wire       wrStrobe;
    wire       initDone;
    wire       wdDone;
    wire       wdRunning;
    wire       limpEntry;
    wire       enterInit;

    // Reads stall one cycle so registered data stand when waitrequest drops
    assign waitrequest = read && !readPending;

    always @* begin
        serialOk = 1'b0;
        case (state)
            `ST_ACTIVE: serialOk = 1'b1;
            `ST_LPM:    serialOk = 1'b1;
            `ST_LIMP:   serialOk = logicAboveRising;   // see RULE_15
            default:    serialOk = 1'b0;               // see RULE_11
        endcase
    end

    assign wrStrobe = write && serialOk;

    // ************************************************************
    // Transition conditions
    // ************************************************************
    assign limpEntry = !logicAboveFalling || limpHomeInput ||
                       (wdEnable && wdDone);            // see RULE_12
    assign enterInit = (state == `ST_SLEEP) && !chipSelect_n &&
                       logicAboveRising;                // see RULE_05

    always @* begin
        next_state = state;
        case (state)
            `ST_OFF: begin
                if (batteryAbovePor)
                    next_state = `ST_SLEEP;             // see RULE_02
            end
            `ST_SLEEP: begin
                if (enterInit)
                    next_state = `ST_INIT;              // see RULE_05
            end
            `ST_INIT: begin
                if (initDone)
                    next_state = `ST_ACTIVE;            // see RULE_20
            end
            `ST_ACTIVE: begin
                if (limpEntry)
                    next_state = `ST_LIMP;              // see RULE_12
                else if (!batteryAboveFalling && logicAboveRising)
                    next_state = `ST_UVLO;              // see RULE_09
                else if (cmdSleep)
                    next_state = `ST_SLEEP;             // see RULE_02
                else if (cmdLpmEnter)
                    next_state = `ST_LPM;               // see RULE_08
            end
            `ST_LPM: begin
                if (cmdLpmExit || loadCurrentRise)
                    next_state = `ST_INIT;              // see RULE_20
            end
            `ST_UVLO: begin
                if (batteryAboveFalling && batteryAbovePor && logicAboveRising)
                    next_state = `ST_ACTIVE;            // see RULE_10
            end
            `ST_LIMP: begin
                if (logicAboveRising && limpHomeStatusFlag && !limpHomeInput)
                    next_state = `ST_ACTIVE;            // see RULE_13
            end
            default: next_state = `ST_OFF;              // see RULE_21
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst)
            state <= `ST_OFF;                           // see RULE_01
        else
            state <= next_state;
    end

    // ************************************************************
    // Timers: init/self-test and serial watchdog
    // ************************************************************
    cycle_timer #(.WIDTH(16)) initTimer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (state != `ST_INIT && next_state == `ST_INIT),
        .stop    (1'b0),
        .load    (INIT_LOAD),
        .running (),
        .done    (initDone)
    );

    // Watchdog only counts in ACTIVE and is re-armed by every kick
    cycle_timer #(.WIDTH(16)) wdTimer (
        .clk_sys (clk_sys),
        .rst     (rst),
        .start   (state == `ST_ACTIVE && (wdKick || !wdRunning) && !wdDone),
        .stop    (state != `ST_ACTIVE || !wdEnable),
        .load    (WD_LOAD),
        .running (wdRunning),
        .done    (wdDone)
    );

    // ************************************************************
    // Register file
    // ************************************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            switchState        <= 2'h0;
            parallel           <= 1'b0;
            wdEnable           <= 1'b0;
            porFlag            <= 1'b1;
            limpHomeStatusFlag <= 1'b0;
            regsValid          <= 1'b0;
            cmdSleep           <= 1'b0;
            cmdLpmEnter        <= 1'b0;
            cmdLpmExit         <= 1'b0;
            wdKick             <= 1'b0;
        end else begin
            cmdSleep    <= 1'b0;
            cmdLpmEnter <= 1'b0;
            cmdLpmExit  <= 1'b0;
            wdKick      <= 1'b0;
            if (state == `ST_OFF || state == `ST_SLEEP) begin
                // Core unpowered: contents lost, reset marker raised
                switchState        <= 2'h0;             // see RULE_03
                parallel           <= 1'b0;
                wdEnable           <= 1'b0;
                regsValid          <= 1'b0;
                limpHomeStatusFlag <= 1'b0;
                porFlag            <= 1'b1;             // see RULE_19
            end else begin
                if (state == `ST_ACTIVE && next_state == `ST_LIMP)
                    limpHomeStatusFlag <= 1'b1;
                else if (wrStrobe && address == `REG_CONTROL &&
                         writedata[`CTL_LH_CLEAR_BIT])
                    limpHomeStatusFlag <= 1'b0;
                if (wrStrobe && address == `REG_CONTROL) begin
                    cmdSleep    <= writedata[`CTL_SLEEP_BIT];
                    cmdLpmEnter <= writedata[`CTL_LPM_ENTER_BIT];  // see RULE_16
                    cmdLpmExit  <= writedata[`CTL_LPM_EXIT_BIT];   // see RULE_16
                    wdKick      <= writedata[`CTL_WD_KICK_BIT];
                    if (state == `ST_ACTIVE)
                        wdEnable <= writedata[`CTL_WD_ENABLE_BIT];
                    if (writedata[`CTL_POR_CLEAR_BIT])
                        porFlag <= 1'b0;
                end
                // Outputs frozen in low-power mode; config is kept there
                if (wrStrobe && address == `REG_CHANNEL && state == `ST_ACTIVE) begin
                    switchState <= writedata[`CH_SWITCH_LSB +: 2];  // see RULE_07
                    regsValid   <= 1'b1;
                    if (switchState == 2'h0)
                        parallel <= writedata[`CH_PARALLEL_BIT];   // see RULE_18
                end
            end
        end
    end

    // ************************************************************
    // Read path
    // ************************************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            readdata    <= 32'h0000_0000;
            readPending <= 1'b0;
        end else begin
            readPending <= read && !readPending;
            if (read && !readPending) begin
                readdata <= 32'h0000_0000;
                if (serialOk) begin
                    case (address)
                        `REG_STATUS: begin
                            readdata[`ST_STATE_LSB +: 3]  <= state;
                            readdata[`ST_POR_BIT]         <= porFlag;
                            readdata[`ST_LH_BIT]          <= limpHomeStatusFlag;
                            readdata[`ST_WD_EN_BIT]       <= wdEnable;
                            readdata[`ST_REGS_VALID_BIT]  <= regsValid;
                        end
                        `REG_CHANNEL: begin
                            readdata[`CH_SWITCH_LSB +: 2] <= switchState;
                            readdata[`CH_PARALLEL_BIT]    <= parallel;
                        end
                        default: readdata <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // ************************************************************
    // Output drive per state
    // ************************************************************
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            channelOutput <= 2'h0;
            coreOn        <= 1'b0;
            diagEnable    <= 1'b0;
            lowPowerOn    <= 1'b0;
        end else begin
            channelOutput <= 2'h0;
            coreOn        <= 1'b0;
            diagEnable    <= 1'b0;
            lowPowerOn    <= 1'b0;
            case (next_state)
                `ST_INIT:   coreOn <= 1'b1;
                `ST_ACTIVE: begin
                    coreOn        <= 1'b1;
                    diagEnable    <= 1'b1;              // see RULE_07
                    channelOutput <= parallel ? {2{switchState[0]}} : switchState;
                end
                `ST_LPM: begin
                    coreOn        <= 1'b1;
                    lowPowerOn    <= 1'b1;              // see RULE_17
                    channelOutput <= parallel ? {2{switchState[0]}} : switchState;  // see RULE_08
                end
                `ST_UVLO:   coreOn <= 1'b1;             // see RULE_11
                `ST_LIMP: begin
                    coreOn        <= 1'b1;
                    diagEnable    <= logicAboveRising;  // see RULE_15
                    channelOutput <= limpHomeChannelLevel | directChannelInput;  // see RULE_14
                end
                default: coreOn <= 1'b0;                // see RULE_03
            endcase
        end
    end
endmodule

`default_nettype wire

// [tb/switch_osm_props.sv]
// Assertion checker for the switch operating-state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "switch_state_map.vh"
module switch_osm_props (
    // Clock, reset and supply monitors
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic       batteryAboveFalling,
    input wire logic       logicAboveRising,
    input wire logic       logicAboveFalling,
    // Pins and outputs
    input wire logic       chipSelect_n,
    input wire logic       limpHomeInput,
    input wire logic [1:0] limpHomeChannelLevel,
    input wire logic [1:0] directChannelInput,
    input wire logic [1:0] channelOutput,
    input wire logic [2:0] state,
    input wire logic       coreOn,
    input wire logic       lowPowerOn
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic goodLogic;
    assign goodLogic = logicAboveRising && logicAboveFalling;
    property p_rst; $fell(rst) |-> state == `ST_OFF && !coreOn && channelOutput == 2'h0; endproperty
    a_rst: assert property (p_rst) else $error("not off after reset");
    property p_sleep; state == `ST_SLEEP |-> !coreOn && channelOutput == 2'h0; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep outputs wrong");
    property p_wake; state == `ST_SLEEP && !chipSelect_n && logicAboveRising |=> state == `ST_INIT;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake");
    property p_init; $rose(state == `ST_INIT) |-> ##[190:210] state == `ST_ACTIVE; endproperty
    a_init: assert property (p_init) else $error("init length wrong");
    // Limp-home wins over undervoltage, so the input must be low here
    property p_uv_in; state == `ST_ACTIVE && !batteryAboveFalling && goodLogic && !limpHomeInput
        |=> state == `ST_UVLO; endproperty
    a_uv_in: assert property (p_uv_in) else $error("no undervoltage entry");
    property p_uv_out; state == `ST_UVLO |-> coreOn && channelOutput == 2'h0; endproperty
    a_uv_out: assert property (p_uv_out) else $error("undervoltage outputs wrong");
    property p_limp_in; state == `ST_ACTIVE && limpHomeInput |=> state == `ST_LIMP; endproperty
    a_limp_in: assert property (p_limp_in) else $error("no limp entry");
    property p_limp_out; state == `ST_LIMP && $past(state) == `ST_LIMP
        && $stable(limpHomeChannelLevel) && $stable(directChannelInput)
        |-> channelOutput == (limpHomeChannelLevel | directChannelInput); endproperty
    a_limp_out: assert property (p_limp_out) else $error("limp outputs wrong");
    property p_limp_back; state == `ST_LIMP && $past(state) == `ST_LIMP && goodLogic
        && !limpHomeInput |=> state == `ST_ACTIVE; endproperty
    a_limp_back: assert property (p_limp_back) else $error("no limp exit");
    property p_lpm; lowPowerOn == (state == `ST_LPM); endproperty
    a_lpm: assert property (p_lpm) else $error("low-power flag wrong");
    property p_legal; state <= `ST_LIMP; endproperty
    a_legal: assert property (p_legal) else $error("illegal state code");
endmodule
`default_nettype wire

// [tb/host_wake_model.sv]
// Host model: dummy frame that wakes the device, then the ready interval
`timescale 1ns/1ps
`default_nettype none
module host_wake_model #(
    parameter integer READY_CYCLES = 220
) (
    // Clock and bench request
    input  wire logic clk_sys,
    input  wire logic wakeReq,
    // Towards the device
    output var  logic chipSelect_n,
    output var  logic ready
);
    int count = 0;
    initial chipSelect_n = 1'b1;
    initial ready = 1'b0;
    // Chip select low for five cycles, no data: only a wake trigger
    always @(posedge clk_sys) begin
        if (wakeReq) begin
            chipSelect_n <= 1'b0;
            ready        <= 1'b0;
            count        <= READY_CYCLES + 4;
        end else if (count > 0) begin
            count <= count - 1;
            if (count == READY_CYCLES) chipSelect_n <= 1'b1;
            if (count == 1) ready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_switch_operating_state_machine.sv]
// Self-checking bench for the switch operating-state sequencer
`timescale 1ns/1ps
`default_nettype none
`include "switch_state_map.vh"
module tb_switch_operating_state_machine;
    // ********************
    // Signals
    // ********************
    logic        clk_sys, rst, read, write, wakeReq, loadCurrentRise, limpHomeInput;
    logic        batteryAbovePor, batteryAboveFalling, logicAboveRising, logicAboveFalling;
    logic [3:0]  address;
    logic [31:0] writedata;
    logic [1:0]  limpHomeChannelLevel, directChannelInput, sw, ch, lv, dv;
    logic [63:0] expNow;
    logic [63:0] expQ[$];
    wire  [31:0] readdata;
    wire         waitrequest, chipSelect_n, ready, coreOn, diagEnable, lowPowerOn;
    wire  [1:0]  channelOutput;
    wire  [2:0]  state;
    int          errors, checks;
    switch_operating_state_machine uut (.clk_sys(clk_sys), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .batteryAbovePor(batteryAbovePor),
        .batteryAboveFalling(batteryAboveFalling), .logicAboveRising(logicAboveRising),
        .logicAboveFalling(logicAboveFalling), .chipSelect_n(chipSelect_n),
        .limpHomeInput(limpHomeInput), .limpHomeChannelLevel(limpHomeChannelLevel),
        .directChannelInput(directChannelInput), .loadCurrentRise(loadCurrentRise),
        .channelOutput(channelOutput), .state(state), .coreOn(coreOn),
        .diagEnable(diagEnable), .lowPowerOn(lowPowerOn));
    host_wake_model host (.clk_sys(clk_sys), .wakeReq(wakeReq), .chipSelect_n(chipSelect_n),
        .ready(ready));
    // ********************
    // Tasks
    // ********************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim;
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic fail;
        errors++;
        $display("[ERR] %0t wait ran out", $time);
        end_sim();
    endtask
    // Request held until waitrequest is seen low, then one idle edge
    task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
        int n = 0;
        address   <= a;
        writedata <= d;
        read      <= rd;
        write     <= !rd;
        @(posedge clk_sys);
        while (waitrequest !== 1'b0) begin
            if (++n > 50) fail();
            @(posedge clk_sys);
        end
        read    <= 1'b0;
        write   <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        expQ.push_back({m, e});
        bus(1'b1, a, 32'h0000_0000);
    endtask
    task automatic waitSt(input logic [2:0] s, input int lim);
        for (int n = 0; n < lim; n++) begin
            @(negedge clk_sys);
            if (state === s) break;
        end
        if (state !== s) fail();
        chk(state, s);
        @(posedge clk_sys);
    endtask
    task automatic wake;
        wakeReq <= 1'b1;
        @(posedge clk_sys);
        wakeReq <= 1'b0;
        @(posedge clk_sys);
        for (int n = 0; n < 400 && ready !== 1'b1; n++) @(posedge clk_sys);
        if (ready !== 1'b1) fail();
    endtask
    // Read data are taken at the edge at which waitrequest is seen low
    always @(posedge clk_sys) begin
        if (read === 1'b1 && waitrequest === 1'b0) begin
            expNow = expQ.pop_front();
            chk(readdata & expNow[63:32], expNow[31:0]);
        end
    end
    // ********************
    // Stimulus
    // ********************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        void'($urandom(96));
        {rst, read, write, wakeReq, loadCurrentRise, limpHomeInput} = 6'h20;
        {batteryAbovePor, batteryAboveFalling, logicAboveRising, logicAboveFalling} = 4'h0;
        {limpHomeChannelLevel, directChannelInput, address} = 8'h00;
        writedata = 32'h0000_0000;
        errors = 0;
        checks = 0;
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({state, coreOn, channelOutput}, 6'h00);
        // Supplies go up here and stay up through sleep
        {batteryAbovePor, batteryAboveFalling, logicAboveRising, logicAboveFalling} <= 4'hF;
        waitSt(`ST_SLEEP, 5);
        chk({coreOn, channelOutput}, 3'h0);
        rd(`REG_STATUS, 32'hFFFF_FFFF, 32'h0000_0000);
        wake();
        waitSt(`ST_ACTIVE, 20);
        chk({coreOn, diagEnable}, 2'h3);
        rd(`REG_STATUS, 32'h0000_007F, 32'h0000_0013);
        wr(`REG_CONTROL, 32'h0000_0020);
        rd(`REG_STATUS, 32'h0000_0017, 32'h0000_0003);
        sw = 2'($urandom_range(3, 1));
        ch = {sw[0], sw[0]}; // Parallel pair follows channel one
        wr(`REG_CHANNEL, 32'h0000_0004);
        wr(`REG_CHANNEL, {29'h0000_0000, 1'b1, sw});
        wr(`REG_CHANNEL, {30'h0000_0000, sw});
        rd(`REG_CHANNEL, 32'h0000_0007, {29'h0000_0000, 1'b1, sw});
        chk(channelOutput, ch);
        for (int i = 0; i < 2; i++) begin
            wr(`REG_CONTROL, 32'h0000_0002);
            waitSt(`ST_LPM, 10);
            chk({lowPowerOn, channelOutput}, {1'b1, ch});
            rd(`REG_CHANNEL, 32'h0000_0007, {29'h0000_0000, 1'b1, sw});
            if (i == 0) wr(`REG_CONTROL, 32'h0000_0004);
            else loadCurrentRise <= 1'b1;
            waitSt(`ST_ACTIVE, 250);
            loadCurrentRise <= 1'b0;
        end
        batteryAboveFalling <= 1'b0;
        waitSt(`ST_UVLO, 10);
        chk({coreOn, channelOutput}, 3'h4);
        rd(`REG_CHANNEL, 32'hFFFF_FFFF, 32'h0000_0000);
        batteryAboveFalling <= 1'b1;
        waitSt(`ST_ACTIVE, 10);
        rd(`REG_CHANNEL, 32'h0000_0007, {29'h0000_0000, 1'b1, sw});
        // First pass by the limp-home input, second by a logic supply drop
        for (int i = 0; i < 2; i++) begin
            lv = 2'($urandom);
            dv = 2'($urandom);
            limpHomeChannelLevel <= lv;
            directChannelInput   <= dv;
            if (i == 0) limpHomeInput <= 1'b1;
            else {logicAboveRising, logicAboveFalling} <= 2'h0;
            waitSt(`ST_LIMP, 10);
            @(posedge clk_sys);
            chk({diagEnable, channelOutput}, {i == 0, lv | dv});
            if (i == 0) rd(`REG_STATUS, 32'h0000_0027, 32'h0000_0026);
            {limpHomeInput, logicAboveRising, logicAboveFalling} <= 3'h3;
            waitSt(`ST_ACTIVE, 10);
        end
        wr(`REG_CONTROL, 32'h0000_0008);
        rd(`REG_STATUS, 32'h0000_0040, 32'h0000_0040);
        waitSt(`ST_LIMP, 10100);
        waitSt(`ST_ACTIVE, 10);
        wr(`REG_CONTROL, 32'h0000_0001);
        waitSt(`ST_SLEEP, 10);
        wake();
        rd(`REG_CHANNEL, 32'h0000_0007, 32'h0000_0000);
        rd(`REG_STATUS, 32'h0000_0017, 32'h0000_0013);
        rst <= 1'b1;
        @(negedge clk_sys);
        chk({state, coreOn, channelOutput}, 6'h00);
        @(posedge clk_sys);
        rst <= 1'b0;
        waitSt(`ST_SLEEP, 5);
        end_sim();
    end
endmodule
bind switch_operating_state_machine switch_osm_props props (.clk_sys(clk_sys), .rst(rst),
    .batteryAboveFalling(batteryAboveFalling), .logicAboveRising(logicAboveRising),
    .logicAboveFalling(logicAboveFalling), .chipSelect_n(chipSelect_n),
    .limpHomeInput(limpHomeInput), .limpHomeChannelLevel(limpHomeChannelLevel),
    .directChannelInput(directChannelInput), .channelOutput(channelOutput),
    .state(state), .coreOn(coreOn), .lowPowerOn(lowPowerOn));
`default_nettype wire
